// file: rtl/hwwdt_watchdog.v
`timescale 1ns/1ns
`default_nettype none
`include "hwwdt_map.vh"

module hwwdt_watchdog (
  input wire clk,
  input wire reset_n,
  input wire restartWrEn,
  input wire [7:0] restartWrData,
  input wire durationWrEn,
  input wire [7:0] durationWrData,
  input wire otherInstr,
  input wire powerDown,
  input wire wakeInt_n,
  output wire [7:0] durationRdData,
  output reg watchdogArmed_r,
  output reg chipReset_r
);
  reg rstMeta_r;
  reg rstSync_r;
  reg [`HWWDT_MC_W-1:0] mcDiv_r;
  localparam KEY_IDLE = 1'b0;
  localparam KEY_HALF = 1'b1;
  reg keyState_r;
  reg keyState_nxt;
  reg watchdogArmed_nxt;
  reg [`HWWDT_SEL_MSB:0] durSel_r;
  reg [`HWWDT_PULSE_W-1:0] pulseCnt_r;
  reg [`HWWDT_PULSE_W-1:0] pulseCnt_nxt;
  reg chipReset_nxt;
  reg wakeHold_r;
  reg powerDown_r;
  wire mcTick;
  wire keyDone;
  wire countEn;
  wire [`HWWDT_POST_W-1:0] postMask;
  wire overflow;
  wire countClear;
  wire postStep;
  wire [`HWWDT_PRE_W-1:0] preCnt;
  wire [`HWWDT_POST_W-1:0] postCnt;

  // Asynchronous assert, synchronous release
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rstMeta_r <= 1'b0;
      rstSync_r <= 1'b0;
    end else begin
      rstMeta_r <= 1'b1;
      rstSync_r <= rstMeta_r;
    end
  end

  assign mcTick = (mcDiv_r == `HWWDT_OSC_PER_MC - 4'h1);
  assign keyDone = (keyState_r == KEY_HALF) && restartWrEn &&
    (restartWrData == `HWWDT_KEY_SECOND);
  // Oscillator is stopped in power-down, so no machine cycles pass
  assign countEn = watchdogArmed_r && mcTick && !powerDown &&
    !wakeHold_r;
  assign postMask = ~(`HWWDT_POST_ALL << durSel_r);
  assign overflow = countEn && (preCnt == `HWWDT_PRE_FULL) &&
    ((postCnt & postMask) == postMask);
  assign countClear = keyDone || overflow;
  assign postStep = countEn && (preCnt == `HWWDT_PRE_FULL);
  assign durationRdData = {5'h00, durSel_r};

  always @(posedge clk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      mcDiv_r <= {`HWWDT_MC_W{1'b0}};
    end else if (powerDown) begin
      mcDiv_r <= {`HWWDT_MC_W{1'b0}};
    end else if (mcTick) begin
      mcDiv_r <= {`HWWDT_MC_W{1'b0}};
    end else begin
      mcDiv_r <= mcDiv_r + 4'h1;
    end
  end

  // Unlock sequence tracker; idle cycles are not instructions
  always @* begin
    keyState_nxt = keyState_r;
    case (keyState_r)
      KEY_IDLE: begin
        if (restartWrEn && (restartWrData == `HWWDT_KEY_FIRST)) begin
          keyState_nxt = KEY_HALF;
        end
      end
      KEY_HALF: begin
        if (restartWrEn) begin
          if (restartWrData == `HWWDT_KEY_FIRST) begin
            keyState_nxt = KEY_HALF;
          end else begin
            keyState_nxt = KEY_IDLE;
          end
        end else if (otherInstr || durationWrEn) begin
          keyState_nxt = KEY_IDLE;
        end
      end
      default: begin
        keyState_nxt = KEY_IDLE;
      end
    endcase
  end

  always @(posedge clk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      keyState_r <= KEY_IDLE;
    end else begin
      keyState_r <= keyState_nxt;
    end
  end

  // Arm state; overflow disarms as the chip reset would
  always @* begin
    watchdogArmed_nxt = watchdogArmed_r;
    if (overflow) begin
      watchdogArmed_nxt = 1'b0;
    end else if (keyDone) begin
      watchdogArmed_nxt = 1'b1;
    end
  end

  always @(posedge clk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      watchdogArmed_r <= 1'b0;
    end else begin
      watchdogArmed_r <= watchdogArmed_nxt;
    end
  end

  always @(posedge clk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      durSel_r <= `HWWDT_SEL_RESET;
    end else if (overflow) begin
      durSel_r <= `HWWDT_SEL_RESET;
    end else if (durationWrEn && !watchdogArmed_r) begin
      durSel_r <= durationWrData[`HWWDT_SEL_MSB:`HWWDT_SEL_LSB];
    end
  end

  // Prescale stage carries into the programmable stage
  hwwdt_count #(
    .W(`HWWDT_PRE_W)
  ) preStage (
    .clk(clk),
    .rstIn_n(rstSync_r),
    .clear(countClear),
    .step(countEn),
    .count_r(preCnt)
  );

  hwwdt_count #(
    .W(`HWWDT_POST_W)
  ) postStage (
    .clk(clk),
    .rstIn_n(rstSync_r),
    .clear(countClear),
    .step(postStep),
    .count_r(postCnt)
  );

  // Wake by level interrupt: hold off until the line is released
  always @(posedge clk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      powerDown_r <= 1'b0;
      wakeHold_r <= 1'b0;
    end else begin
      powerDown_r <= powerDown;
      if (wakeInt_n) begin
        wakeHold_r <= 1'b0;
      end else if (powerDown_r && !powerDown) begin
        wakeHold_r <= 1'b1;
      end
    end
  end

  // Reset pulse; its own counter survives the chip reset it causes
  always @* begin
    pulseCnt_nxt = pulseCnt_r;
    chipReset_nxt = chipReset_r;
    if (overflow) begin
      pulseCnt_nxt = `HWWDT_PULSE_LAST;
      chipReset_nxt = 1'b1;
    end else if (pulseCnt_r != {`HWWDT_PULSE_W{1'b0}}) begin
      pulseCnt_nxt = pulseCnt_r - 7'h01;
    end else begin
      chipReset_nxt = 1'b0;
    end
  end

  always @(posedge clk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      pulseCnt_r <= {`HWWDT_PULSE_W{1'b0}};
      chipReset_r <= 1'b0;
    end else begin
      pulseCnt_r <= pulseCnt_nxt;
      chipReset_r <= chipReset_nxt;
    end
  end
endmodule

// Counter stage; clear wins over step, but a service still loses to an overflow in the same cycle
module hwwdt_count #(
  parameter W = 14
) (
  input wire clk,
  input wire rstIn_n,
  input wire clear,
  input wire step,
  output reg [W-1:0] count_r
);
  always @(posedge clk or negedge rstIn_n) begin
    if (!rstIn_n) begin
      count_r <= {W{1'b0}};
    end else if (clear) begin
      count_r <= {W{1'b0}};
    end else if (step) begin
      count_r <= count_r + {{(W-1){1'b0}}, 1'b1};
    end
  end
endmodule
`default_nettype wire

// file: rtl/hwwdt_map.vh
`ifndef HWWDT_MAP_VH
`define HWWDT_MAP_VH
// Unlock and service bytes
`define HWWDT_KEY_FIRST 8'h1e
`define HWWDT_KEY_SECOND 8'he1
// Duration select field
`define HWWDT_SEL_MSB 2
`define HWWDT_SEL_LSB 0
`define HWWDT_SEL_RESET 3'h0
// Count chain widths
`define HWWDT_PRE_W 14
`define HWWDT_POST_W 7
`define HWWDT_PRE_FULL 14'h3fff
`define HWWDT_POST_ALL 7'h7f
// Oscillator periods per machine cycle
`define HWWDT_OSC_PER_MC 4'hc
`define HWWDT_MC_W 4
// Reset pulse length in oscillator periods; clk is the oscillator
`define HWWDT_PULSE_OSC 96
// Counter loads one less, since the loading edge counts too
`define HWWDT_PULSE_LAST 7'h5f
`define HWWDT_PULSE_W 7
`endif

// file: tb/hwwdt_props.sv
`timescale 1ns/1ns
`default_nettype none
module hwwdt_props (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic restartWrEn,
  input wire logic [7:0] restartWrData,
  input wire logic durationWrEn,
  input wire logic [7:0] durationWrData,
  input wire logic otherInstr,
  input wire logic [7:0] durationRdData,
  input wire logic watchdogArmed_r,
  input wire logic chipReset_r
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire k1 = restartWrEn && restartWrData == 8'h1e;
  wire k2 = restartWrEn && restartWrData == 8'he1;
  AST_ARM: assert property (k1 ##1 k2 |=> watchdogArmed_r)
    else $error("no arm");
  AST_ARMSRC: assert property ($rose(watchdogArmed_r) |->
    $past(k2) && $past(k1, 2)) else $error("bad arm");
  AST_BREAK: assert property (!watchdogArmed_r && k1 ##1
    otherInstr && !restartWrEn ##1 k2 |=> !watchdogArmed_r)
    else $error("arm");
  AST_STAY: assert property ($fell(watchdogArmed_r) |=> chipReset_r)
    else $error("disarm");
  AST_PULSE: assert property ($rose(chipReset_r) |->
    ##95 chipReset_r ##1 !chipReset_r) else $error("pulse");
  AST_IDLE: assert property ((!watchdogArmed_r)[*2] ##0 !chipReset_r
    |=> !chipReset_r) else $error("reset");
  AST_LOCK: assert property (watchdogArmed_r && durationWrEn
    ##1 watchdogArmed_r |-> $stable(durationRdData)) else $error("lock");
  AST_SEL: assert property (!watchdogArmed_r && durationWrEn |=>
    durationRdData == {5'h00, $past(durationWrData[2:0])}) else $error("sel");
  cover property ($rose(watchdogArmed_r));
  cover property (watchdogArmed_r && durationWrEn);
  cover property (watchdogArmed_r && k1 ##1 k2);
  cover property ($rose(chipReset_r));
endmodule
bind hwwdt_watchdog hwwdt_props chk (.clk, .reset_n, .restartWrEn,
  .restartWrData, .durationWrEn, .durationWrData, .otherInstr,
  .durationRdData, .watchdogArmed_r, .chipReset_r);
`default_nettype wire

// file: tb/hw_watchdog_timer_bench.sv
`timescale 1ns/1ns
`default_nettype none
module hw_watchdog_timer_bench;
  logic clk = 1'h0, reset_n = 1'h0, rw = 1'h0, dw = 1'h0, oi = 1'h0;
  logic pd = 1'h0, wk = 1'h1;
  logic [7:0] rd = 8'h00, dd = 8'h00;
  wire [9:0] q;
  int num_errors = 0, checked = 0;
  always #2 clk = ~clk;
  hwwdt_watchdog DUT (.clk, .reset_n, .restartWrEn(rw), .restartWrData(rd),
    .durationWrEn(dw), .durationWrData(dd), .otherInstr(oi), .powerDown(pd),
    .wakeInt_n(wk), .durationRdData(q[7:0]), .watchdogArmed_r(q[8]),
    .chipReset_r(q[9]));
  // One event per cycle: restart write, duration write, other instruction
  task automatic go(input logic [7:0] d, input logic [2:0] k);
    @(negedge clk);
    {rw, dw, oi} = k;
    {rd, dd} = {d, d};
  endtask
  task automatic chk(input logic [9:0] e);
    repeat (2) go(8'h00, 3'h0);
    checked++;
    if (q !== e) begin
      num_errors++;
      $display("wrong value at %0t: %h not %h", $time, q, e);
    end
  endtask
  task automatic end_sim;
    $display("errors %0d of %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic t_idle;
    repeat (3) go(8'h00, 3'h0);
    go(8'he1, 3'h4);
    chk(10'h000);
    go(8'hfd, 3'h2);
    chk(10'h005);
  endtask
  task automatic t_broken;
    go(8'h1e, 3'h4);
    go(8'h00, 3'h1);
    go(8'he1, 3'h4);
    go(8'h1e, 3'h4);
    go(8'hfd, 3'h2);
    go(8'he1, 3'h4);
    chk(10'h005);
  endtask
  // Full timeout is far beyond the run budget, so only arming is seen
  task automatic t_arm;
    go(8'h1e, 3'h4);
    go(8'he1, 3'h4);
    go(8'h02, 3'h2);
    chk(10'h105);
    {pd, wk} = 2'h2;
    repeat (30) go(8'h00, 3'h0);
    pd = 1'h0;
    repeat (30) go(8'h00, 3'h0);
    wk = 1'h1;
    go(8'h1e, 3'h4);
    go(8'he1, 3'h4);
    chk(10'h105);
  endtask
  // Hardware reset out of power-down while armed, then arm again
  task automatic t_reset;
    pd = 1'h1;
    go(8'h00, 3'h0);
    reset_n = 1'h0;
    repeat (2) go(8'h00, 3'h0);
    {reset_n, pd} = 2'h2;
    chk(10'h000);
    go(8'h07, 3'h2);
    go(8'h1e, 3'h4);
    go(8'he1, 3'h4);
    chk(10'h107);
  endtask
  initial begin
    repeat (20) @(negedge clk);
    reset_n = 1'h1;
    t_idle;
    t_broken;
    t_arm;
    t_reset;
    end_sim;
  end
endmodule
`default_nettype wire
